// file: hw/ivih_defines.svh
// Offsets, codes, field positions and timing of the image install handler.
`ifndef IVIH_DEFINES_SVH
`define IVIH_DEFINES_SVH

`define IVIH_CMD_ERASE 8'h01
`define IVIH_CMD_WRITE 8'h02
`define IVIH_CMD_VERIFY 8'h05
`define IVIH_CMD_APPLY 8'h06
`define IVIH_RSP_VERIFY 8'h85
`define IVIH_RSP_APPLY 8'h86
`define IVIH_FLAG_GOOD 8'h00
`define IVIH_FLAG_BAD 8'h01

`define IVIH_BLK_SIZE 512
`define IVIH_MEM_AW 17

`define IVIH_INSTALL_S 8
`define IVIH_CLK_HZ 50000000
`define IVIH_INSTALL_CYC (`IVIH_INSTALL_S * `IVIH_CLK_HZ)

`define IVIH_OFS_IMG_LEN 12'h000
`define IVIH_OFS_IMG_SUM 12'h004
`define IVIH_OFS_STATUS 12'h008
`define IVIH_OFS_IRQ_STAT 12'h00C
`define IVIH_OFS_IRQ_CLR 12'h010
`define IVIH_OFS_IRQ_EN 12'h014
`define IVIH_OFS_MEM_ADDR 12'h018
`define IVIH_OFS_MEM_DATA 12'h01C

`define IVIH_IRQ_REPLY 0
`define IVIH_IRQ_BAD 1
`define IVIH_IRQ_INST 2
`define IVIH_IRQ_ORDER 3

`define IVIH_RESP_OKAY 2'h0
`define IVIH_RESP_SLVERR 2'h2

`endif

// file: hw/ivih_pkg.sv
// Types shared by the image verify and install handler.
package ivih_pkg;

    typedef logic [11:0] ivih_addr_t;

    typedef struct packed {
        logic radio;
        logic bcast;
        logic [7:0] endpoint;
        logic [7:0] code;
        logic [15:0] block;
        logic [15:0] offset;
        logic [7:0] data;
    } ivih_cmd_t;

    typedef struct packed {
        logic radio;
        logic [7:0] endpoint;
        logic [7:0] code;
        logic [7:0] flags;
        logic [15:0] block;
        logic [15:0] offset;
        logic [15:0] count;
    } ivih_rsp_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_REPLY = 2'b01,
        ST_INSTALL = 2'b10,
        ST_RESET = 2'b11
    } ivih_state_t;

endpackage : ivih_pkg

// file: hw/ivih_scratch_mem.sv
// Byte-wide staging scratch memory with a registered read port.
`timescale 1ns/1ps
`include "ivih_defines.svh"
module ivih_scratch_mem #(
    parameter int AW = `IVIH_MEM_AW
) (
    input wire logic core_clk,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [7:0] rd_data_q
);
    import ivih_pkg::*;

    logic [7:0] mem [0:(1<<AW)-1];

    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data_q <= mem[rd_addr];
    end

endmodule : ivih_scratch_mem

// file: hw/ivih_timer.sv
// Installation timer: busy for a fixed number of cycles after a start.
`timescale 1ns/1ps
`include "ivih_defines.svh"
module ivih_timer #(
    parameter int unsigned CYC = `IVIH_INSTALL_CYC
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic start,
    output logic busy_q,
    output logic done
);
    import ivih_pkg::*;

    logic [31:0] cnt_q;

    // Done is the last busy cycle, so the owner leaves on the CYC-th edge.
    assign done = busy_q && cnt_q == 32'h0;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= 32'h0;
            busy_q <= 1'b0;
        end else if (start && !busy_q) begin
            cnt_q <= CYC - 32'h1;
            busy_q <= 1'b1;
        end else if (done) begin
            busy_q <= 1'b0;
        end else if (busy_q) begin
            cnt_q <= cnt_q - 32'h1;
        end
    end

endmodule : ivih_timer

// file: hw/ivih_handler.sv
// Image verify and install handler with its AXI4-Lite register file.
`timescale 1ns/1ps
`include "ivih_defines.svh"
// What this block does
// - Unicast apply on bad image replies 0x86.
// - Good image: no reply, install, then reset.
// - Apply reply sets result flag bit zero.
// - Apply reply zeroes block, offset, count.
// - Never install an image that fails.
// - Valid only when every byte arrived.
// - Installation ends within eight seconds.
// - Ignore all traffic while installing.
// - Install reset drops uncommitted settings.
// - Install reset drops routing information.
// - Serial and radio share one sequence.
// - Check reply 0x85 flags valid or invalid.
module ivih_handler #(
    parameter int AW = `IVIH_MEM_AW,
    parameter int BLK_SIZE = `IVIH_BLK_SIZE,
    parameter int unsigned INSTALL_CYC = `IVIH_INSTALL_CYC
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic awvalid,
    output logic awready,
    input wire ivih_pkg::ivih_addr_t awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire ivih_pkg::ivih_addr_t araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire ivih_pkg::ivih_cmd_t cmd,
    output logic rsp_valid,
    input wire logic rsp_ready,
    output ivih_pkg::ivih_rsp_t rsp,
    output logic installing,
    output logic module_reset,
    output logic irq
);
    import ivih_pkg::*;

    // ********************************
    // Declarations and helpers
    // ********************************
    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q, wdata_q, len_q, inst_cnt_q;
    logic [3:0] wstrb_q, irq_st_q, irq_en_q, irq_evt;
    ivih_addr_t awaddr_q;
    logic [15:0] sum_q, img_sum_q;
    logic [AW-1:0] mem_addr_q;
    logic [AW:0] next_addr_q;
    logic order_err_q, irq_q, installing_q;
    logic cmd_ready_q, rsp_valid_q, module_reset_q;
    ivih_state_t state_q, state_d;
    ivih_rsp_t rsp_q, rsp_d;
    logic [7:0] mem_rd_data;
    logic timer_busy, timer_done;

    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] wd, input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                r[8*i +: 8] = wd[8*i +: 8];
            end
        end
        return r;
    endfunction : merge

    function automatic logic is_mapped(input ivih_addr_t a);
        return a[1:0] == 2'h0 && a <= `IVIH_OFS_MEM_DATA;
    endfunction : is_mapped

    // ********************************
    // Command decode and image tracking
    // ********************************
    // Only the idle state acts; anything taken elsewhere is swallowed.
    wire cmd_take = cmd_valid && cmd_ready_q;
    wire act = cmd_take && state_q == ST_IDLE;
    wire is_erase = act && cmd.code == `IVIH_CMD_ERASE;
    wire is_write = act && cmd.code == `IVIH_CMD_WRITE;
    wire is_verify = act && cmd.code == `IVIH_CMD_VERIFY;
    wire is_apply = act && cmd.code == `IVIH_CMD_APPLY;
    wire [47:0] wr_abs = 48'(cmd.block) * 48'(BLK_SIZE)
        + 48'(cmd.offset);
    // A write counts only if it lands exactly on the next expected byte.
    wire wr_ok = is_write && wr_abs == 48'(next_addr_q)
        && wr_abs < (48'h1 << AW);
    wire image_ok = len_q != 32'h0 && 32'(next_addr_q) == len_q
        && !order_err_q && sum_q == img_sum_q;
    wire reply = (is_verify || (is_apply && !image_ok))
        && !cmd.bcast;
    wire start_install = is_apply && image_ok;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            next_addr_q <= '0;
            sum_q <= 16'h0;
            order_err_q <= 1'b0;
        end else if (is_erase) begin
            next_addr_q <= '0;
            sum_q <= 16'h0;
            order_err_q <= 1'b0;
        end else if (wr_ok) begin
            next_addr_q <= next_addr_q + 1'b1;
            sum_q <= sum_q + {8'h00, cmd.data};
        end else if (is_write) begin
            order_err_q <= 1'b1;
        end
    end

    ivih_scratch_mem #(
        .AW(AW)
    ) u_mem (
        .core_clk(core_clk),
        .wr_en(wr_ok),
        .wr_addr(wr_abs[AW-1:0]),
        .wr_data(cmd.data),
        .rd_addr(mem_addr_q),
        .rd_data_q(mem_rd_data)
    );

    ivih_timer #(
        .CYC(INSTALL_CYC)
    ) u_timer (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .start(start_install),
        .busy_q(timer_busy),
        .done(timer_done)
    );

    // ********************************
    // Reply and installation sequence
    // ********************************
    always_comb begin
        rsp_d = '0;
        rsp_d.radio = cmd.radio;
        rsp_d.endpoint = cmd.endpoint;
        rsp_d.code = is_apply ? `IVIH_RSP_APPLY : `IVIH_RSP_VERIFY;
        rsp_d.flags = image_ok ? `IVIH_FLAG_GOOD : `IVIH_FLAG_BAD;
    end

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (start_install) begin
                    state_d = ST_INSTALL;
                end else if (reply) begin
                    state_d = ST_REPLY;
                end
            end
            ST_REPLY: begin
                if (rsp_ready) begin
                    state_d = ST_IDLE;
                end
            end
            ST_INSTALL: begin
                if (timer_done) begin
                    state_d = ST_RESET;
                end
            end
            ST_RESET: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // The reset pulse tells the module to drop volatile settings and
    // routes; the scratch memory and its tracking survive it.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= ST_IDLE;
            cmd_ready_q <= 1'b0;
            rsp_valid_q <= 1'b0;
            rsp_q <= '0;
            module_reset_q <= 1'b0;
            installing_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cmd_ready_q <= state_d != ST_REPLY;
            rsp_valid_q <= state_d == ST_REPLY;
            if (reply) begin
                rsp_q <= rsp_d;
            end
            module_reset_q <= state_d == ST_RESET;
            installing_q <= state_d == ST_INSTALL;
        end
    end

    // ********************************
    // AXI4-Lite slave and interrupts
    // ********************************
    wire wr_do = !awready_q && !wready_q && !bvalid_q;
    wire w_len = wr_do && awaddr_q == `IVIH_OFS_IMG_LEN;
    wire w_sum = wr_do && awaddr_q == `IVIH_OFS_IMG_SUM;
    wire w_clr = wr_do && awaddr_q == `IVIH_OFS_IRQ_CLR;
    wire w_en = wr_do && awaddr_q == `IVIH_OFS_IRQ_EN;
    wire w_madr = wr_do && awaddr_q == `IVIH_OFS_MEM_ADDR;
    wire [31:0] len_new = merge(len_q, wdata_q, wstrb_q);
    wire [31:0] sum_new = merge(32'(img_sum_q), wdata_q, wstrb_q);
    wire [31:0] en_new = merge(32'(irq_en_q), wdata_q, wstrb_q);
    wire [31:0] madr_new = merge(32'(mem_addr_q), wdata_q, wstrb_q);
    wire [3:0] irq_clr = w_clr ? wdata_q[3:0] : 4'h0;
    wire [31:0] status_w = {installing_q, image_ok, order_err_q,
        29'(next_addr_q)};
    wire [31:0] rd_mux =
        araddr == `IVIH_OFS_IMG_LEN ? len_q :
        araddr == `IVIH_OFS_IMG_SUM ? 32'(img_sum_q) :
        araddr == `IVIH_OFS_STATUS ? status_w :
        araddr == `IVIH_OFS_IRQ_STAT ? 32'(irq_st_q) :
        araddr == `IVIH_OFS_IRQ_EN ? 32'(irq_en_q) :
        araddr == `IVIH_OFS_MEM_ADDR ? 32'(mem_addr_q) :
        araddr == `IVIH_OFS_MEM_DATA ? 32'(mem_rd_data) : 32'h0;

    always_comb begin
        irq_evt = 4'h0;
        irq_evt[`IVIH_IRQ_REPLY] = rsp_valid_q && rsp_ready;
        irq_evt[`IVIH_IRQ_BAD] = act && (is_verify || is_apply) && !image_ok;
        irq_evt[`IVIH_IRQ_INST] = start_install;
        irq_evt[`IVIH_IRQ_ORDER] = is_write && !wr_ok;
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            arready_q <= 1'b1;
            bvalid_q <= 1'b0;
            rvalid_q <= 1'b0;
            bresp_q <= `IVIH_RESP_OKAY;
            rresp_q <= `IVIH_RESP_OKAY;
            rdata_q <= 32'h0;
            awaddr_q <= '0;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
        end else begin
            if (awvalid && awready_q) begin
                awaddr_q <= awaddr;
                awready_q <= 1'b0;
            end else if (wr_do) begin
                awready_q <= 1'b1;
            end
            if (wvalid && wready_q) begin
                wdata_q <= wdata;
                wstrb_q <= wstrb;
                wready_q <= 1'b0;
            end else if (wr_do) begin
                wready_q <= 1'b1;
            end
            if (wr_do) begin
                bvalid_q <= 1'b1;
                bresp_q <= is_mapped(awaddr_q) ? `IVIH_RESP_OKAY
                    : `IVIH_RESP_SLVERR;
            end else if (bready) begin
                bvalid_q <= 1'b0;
            end
            if (arvalid && arready_q) begin
                arready_q <= 1'b0;
                rvalid_q <= 1'b1;
                rdata_q <= rd_mux;
                rresp_q <= is_mapped(araddr) ? `IVIH_RESP_OKAY
                    : `IVIH_RESP_SLVERR;
            end else if (rvalid_q && rready) begin
                rvalid_q <= 1'b0;
                arready_q <= 1'b1;
            end
        end
    end

    // A new event in the clearing cycle stays set.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            len_q <= 32'h0;
            img_sum_q <= 16'h0;
            irq_en_q <= 4'h0;
            mem_addr_q <= '0;
            irq_st_q <= 4'h0;
            irq_q <= 1'b0;
        end else begin
            len_q <= w_len ? len_new : len_q;
            img_sum_q <= w_sum ? sum_new[15:0] : img_sum_q;
            irq_en_q <= w_en ? en_new[3:0] : irq_en_q;
            mem_addr_q <= w_madr ? madr_new[AW-1:0] : mem_addr_q;
            irq_st_q <= (irq_st_q & ~irq_clr) | irq_evt;
            irq_q <= |(irq_st_q & irq_en_q);
        end
    end

    assign awready = awready_q;
    assign wready = wready_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = arready_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign cmd_ready = cmd_ready_q;
    assign rsp_valid = rsp_valid_q;
    assign rsp = rsp_q;
    assign installing = installing_q;
    assign module_reset = module_reset_q;
    assign irq = irq_q;

    // ********************************
    // Assertions
    // ********************************
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            inst_cnt_q <= 32'h0;
        end else begin
            inst_cnt_q <= state_q == ST_INSTALL ? inst_cnt_q + 32'h1 : 32'h0;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    AST_APPLY_BAD: assert property (
        is_apply && !cmd.bcast && !image_ok
        |=> rsp_valid_q && rsp_q.code == `IVIH_RSP_APPLY)
        else $error("Bad image apply gave no failure reply.");
    AST_APPLY_SILENT: assert property (
        start_install |=> state_q == ST_INSTALL && !rsp_valid_q)
        else $error("Good image apply did not install silently.");
    AST_APPLY_FLAG: assert property (
        rsp_valid_q && rsp_q.code == `IVIH_RSP_APPLY
        |-> rsp_q.flags == `IVIH_FLAG_BAD)
        else $error("Apply reply flag is not one.");
    AST_ZERO_FIELDS: assert property (
        rsp_valid_q |-> rsp_q.block == 16'h0 && rsp_q.offset == 16'h0
        && rsp_q.count == 16'h0)
        else $error("Reply fields are not zero.");
    AST_NO_BAD_INSTALL: assert property (
        (state_q == ST_IDLE ##1 state_q == ST_INSTALL) |-> $past(image_ok))
        else $error("Installation began on a bad image.");
    AST_VALID_FULL: assert property (
        image_ok |-> 32'(next_addr_q) == len_q && !order_err_q)
        else $error("Image valid before every byte arrived.");
    AST_INSTALL_BOUND: assert property (
        state_q == ST_INSTALL |-> inst_cnt_q < INSTALL_CYC)
        else $error("Installation ran past its time bound.");
    AST_INSTALL_DEAF: assert property (
        state_q == ST_INSTALL && cmd_take
        |=> !rsp_valid_q && $stable(next_addr_q) && $stable(sum_q))
        else $error("Traffic acted on during installation.");
    AST_RESET_PULSE: assert property (
        state_q == ST_INSTALL && timer_done
        |=> module_reset_q ##1 !module_reset_q && state_q == ST_IDLE)
        else $error("Install end gave no single reset pulse.");
    AST_ERASE: assert property (
        is_erase |=> next_addr_q == '0 && sum_q == 16'h0 && !order_err_q)
        else $error("Erase did not clear image tracking.");
    AST_SAME_PORT: assert property (
        reply |=> rsp_q.radio == $past(cmd.radio)
        && rsp_q.endpoint == $past(cmd.endpoint))
        else $error("Reply went to another port or endpoint.");
    AST_VERIFY_FLAG: assert property (
        is_verify && !cmd.bcast |=> rsp_q.code == `IVIH_RSP_VERIFY
        && rsp_q.flags[0] == !$past(image_ok))
        else $error("Check reply flag disagrees with image state.");
    AST_ADDR_STEP: assert property (
        wr_ok |=> next_addr_q == $past(next_addr_q) + 1'b1)
        else $error("In-order write did not advance the address.");

    COV_APPLY_FAIL: cover property (is_apply && !image_ok && !cmd.bcast);
    COV_INSTALL: cover property (state_q == ST_INSTALL ##1 module_reset_q);
    COV_VERIFY_OK: cover property (is_verify && image_ok);

endmodule : ivih_handler

// file: tb/ivih_src_model.sv
// Update source model: issues commands and accepts replies.
`timescale 1ns/1ps
module ivih_src_model (
    input wire logic core_clk,
    output logic cmd_valid,
    input wire logic cmd_ready,
    output ivih_pkg::ivih_cmd_t cmd,
    input wire logic rsp_valid,
    output logic rsp_ready,
    input wire ivih_pkg::ivih_rsp_t rsp,
    input wire logic [3:0] stall
);
    import ivih_pkg::*;
    int rsp_cnt = 0;
    int wait_q = 0;
    ivih_rsp_t last_rsp;
    initial begin
        cmd_valid = 1'b0;
        cmd = '0;
        rsp_ready = 1'b0;
    end
    // The idle payload is inverted so a stale command cannot look valid.
    task automatic send(input ivih_cmd_t c, output bit ok);
        ok = 1'b0;
        @(posedge core_clk);
        cmd_valid <= 1'b1;
        cmd <= c;
        for (int n = 0; n < 200 && !ok; n++) begin
            @(posedge core_clk);
            ok = cmd_ready;
        end
        cmd_valid <= 1'b0;
        cmd <= ~c;
    endtask : send
    // A reply is taken only after a stall, to exercise a slow source.
    always @(posedge core_clk) begin
        if (rsp_valid && rsp_ready) begin
            last_rsp <= rsp;
            rsp_cnt <= rsp_cnt + 1;
            rsp_ready <= 1'b0;
            wait_q <= 0;
        end else if (rsp_valid) begin
            rsp_ready <= (wait_q >= stall);
            wait_q <= wait_q + 1;
        end
    end
endmodule : ivih_src_model

// file: tb/ivih_handler_tb.sv
// Self-checking testbench of the image verify and install handler.
`timescale 1ns/1ps
`include "ivih_defines.svh"
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin \
    fail_count++; $display("Error at %0t: got %0h expected %0h", \
    $time, (got), (exp)); end end
module ivih_handler_tb;
    import ivih_pkg::*;
    localparam int BLK = 16;
    localparam int INST = 20;
    localparam int N = 40;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    ivih_addr_t awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = '0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, rr;
    logic [31:0] rdata, rd;
    logic cmd_valid, cmd_ready, rsp_valid, rsp_ready;
    ivih_cmd_t cmd, last_cmd;
    ivih_rsp_t rsp;
    logic installing, module_reset, irq;
    logic [3:0] stall = '0;
    logic [31:0] seed = 32'h37A362C1;
    logic [7:0] img [N];
    logic [15:0] sum;
    int fail_count = 0, checks = 0, inst_cyc = 0, rst_cnt = 0, c0;

    always #10 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        if (installing === 1'b1) inst_cyc++;
        if (module_reset === 1'b1) rst_cnt++;
    end

    ivih_handler #(.AW(10), .BLK_SIZE(BLK), .INSTALL_CYC(INST)) DUT (
        .core_clk(core_clk), .rst_b(rst_b),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
        .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp(rsp),
        .installing(installing), .module_reset(module_reset), .irq(irq));
    ivih_src_model src (
        .core_clk(core_clk), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd(cmd), .rsp_valid(rsp_valid),
        .rsp_ready(rsp_ready), .rsp(rsp), .stall(stall));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
    endfunction : lfsr

    // Reply expected for a check or failed apply: unused fields are zero.
    function automatic ivih_rsp_t exp_rsp(input ivih_cmd_t c,
        input logic [7:0] code, input logic [7:0] flags);
        return '{radio: c.radio, endpoint: c.endpoint, code: code,
            flags: flags, block: 16'h0, offset: 16'h0, count: 16'h0};
    endfunction : exp_rsp

    task automatic end_of_test();
        if (fail_count == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_of_test

    task automatic wr(input ivih_addr_t a, input logic [31:0] d);
        bit aw, w, ok;
        aw = 0;
        w = 0;
        ok = 0;
        @(posedge core_clk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        wstrb <= 4'hF;
        bready <= 1'b1;
        for (int n = 0; n < 100 && !ok; n++) begin
            @(posedge core_clk);
            if (!aw && awready) begin
                aw = 1;
                awvalid <= 1'b0;
            end
            if (!w && wready) begin
                w = 1;
                wvalid <= 1'b0;
            end
            if (bvalid) begin
                ok = 1;
                rr = bresp;
                bready <= 1'b0;
            end
        end
        `CHK(ok, 1'b1)
        if (!ok) end_of_test();
    endtask : wr

    task automatic rd_reg(input ivih_addr_t a);
        bit ar, ok;
        ar = 0;
        ok = 0;
        @(posedge core_clk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        for (int n = 0; n < 100 && !ok; n++) begin
            @(posedge core_clk);
            if (!ar && arready) begin
                ar = 1;
                arvalid <= 1'b0;
            end
            if (rvalid) begin
                ok = 1;
                rd = rdata;
                rr = rresp;
                rready <= 1'b0;
            end
        end
        `CHK(ok, 1'b1)
        if (!ok) end_of_test();
    endtask : rd_reg

    // Byte address a is split into block and offset.
    task automatic dc(input logic [7:0] code, input logic [15:0] a,
        input logic [7:0] d, input logic bc);
        bit ok;
        seed = lfsr(seed);
        stall <= seed[19:16];
        last_cmd = '{radio: seed[0], bcast: bc, endpoint: seed[15:8],
            code: code, block: a / BLK, offset: a % BLK, data: d};
        src.send(last_cmd, ok);
        `CHK(ok, 1'b1)
        if (!ok) end_of_test();
    endtask : dc

    task automatic rp(input logic [7:0] code, input logic [7:0] flags);
        int n0;
        n0 = src.rsp_cnt;
        for (int n = 0; n < 60 && src.rsp_cnt == n0; n++) begin
            @(posedge core_clk);
            #1;
        end
        `CHK(src.rsp_cnt, n0 + 1)
        if (src.rsp_cnt == n0) end_of_test();
        `CHK(src.last_rsp, exp_rsp(last_cmd, code, flags))
    endtask : rp

    initial begin
        repeat (6) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge core_clk);
        rd_reg(12'h020);
        `CHK({rr, rd}, {`IVIH_RESP_SLVERR, 32'h0})
        wr(12'h002, 32'h1);
        `CHK(rr, `IVIH_RESP_SLVERR)
        wr(`IVIH_OFS_IRQ_EN, 32'h0);
        dc(`IVIH_CMD_VERIFY, 0, 0, 0);
        rp(`IVIH_RSP_VERIFY, `IVIH_FLAG_BAD);
        c0 = src.rsp_cnt;
        dc(`IVIH_CMD_VERIFY, 0, 0, 1);
        repeat (12) @(posedge core_clk);
        `CHK(src.rsp_cnt, c0)
        dc(`IVIH_CMD_ERASE, 0, 0, 0);
        dc(`IVIH_CMD_WRITE, 5, 8'hAA, 0);
        rd_reg(`IVIH_OFS_STATUS);
        `CHK(rd[29], 1'b1)
        `CHK(irq, 1'b0)
        wr(`IVIH_OFS_IRQ_EN, 32'h8);
        rd_reg(`IVIH_OFS_IRQ_STAT);
        `CHK(rd, 32'hB)
        `CHK(irq, 1'b1)
        wr(`IVIH_OFS_IRQ_CLR, 32'hF);
        rd_reg(`IVIH_OFS_IRQ_STAT);
        `CHK({rd, irq}, 33'h0)
        dc(`IVIH_CMD_ERASE, 0, 0, 0);
        sum = '0;
        for (int i = 0; i < N; i++) begin
            seed = lfsr(seed);
            img[i] = seed[7:0];
            sum += 16'(img[i]);
        end
        wr(`IVIH_OFS_IMG_LEN, N);
        wr(`IVIH_OFS_IMG_SUM, {16'h0, sum});
        for (int i = 0; i < N - 1; i++) dc(`IVIH_CMD_WRITE, i, img[i], 0);
        dc(`IVIH_CMD_VERIFY, 0, 0, 0);
        rp(`IVIH_RSP_VERIFY, `IVIH_FLAG_BAD);
        dc(`IVIH_CMD_APPLY, 0, 0, 0);
        rp(`IVIH_RSP_APPLY, `IVIH_FLAG_BAD);
        `CHK(inst_cyc, 0)
        dc(`IVIH_CMD_WRITE, N - 1, img[N-1], 0);
        rd_reg(`IVIH_OFS_STATUS);
        `CHK(rd, {3'b010, 29'(N)})
        wr(`IVIH_OFS_MEM_ADDR, 17);
        repeat (2) @(posedge core_clk);
        rd_reg(`IVIH_OFS_MEM_DATA);
        `CHK(rd[7:0], img[17])
        wr(`IVIH_OFS_IMG_SUM, {16'h0, sum + 16'h1});
        dc(`IVIH_CMD_VERIFY, 0, 0, 0);
        rp(`IVIH_RSP_VERIFY, `IVIH_FLAG_BAD);
        wr(`IVIH_OFS_IMG_SUM, {16'h0, sum});
        dc(`IVIH_CMD_VERIFY, 0, 0, 0);
        rp(`IVIH_RSP_VERIFY, `IVIH_FLAG_GOOD);
        c0 = src.rsp_cnt;
        dc(`IVIH_CMD_APPLY, 0, 0, 0);
        dc(`IVIH_CMD_VERIFY, 0, 0, 0);
        dc(`IVIH_CMD_APPLY, 0, 0, 0);
        for (int n = 0; n < 200 && rst_cnt == 0; n++) @(posedge core_clk);
        repeat (12) @(posedge core_clk);
        `CHK(src.rsp_cnt, c0)
        `CHK(inst_cyc, INST)
        `CHK(rst_cnt, 1)
        rd_reg(`IVIH_OFS_IRQ_STAT);
        `CHK(rd[`IVIH_IRQ_INST], 1'b1)
        dc(`IVIH_CMD_APPLY, 0, 0, 0);
        repeat (3) @(posedge core_clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge core_clk);
        `CHK({installing, module_reset}, 2'b00)
        rst_b <= 1'b1;
        end_of_test();
    end
endmodule : ivih_handler_tb
